//--- hdl/tmr16_pkg.sv
// package: register map, field positions and shared types of the dual 16-bit timer block
package tmr16_pkg;
	localparam logic [5:0] ADDR_T1_CNT_L   = 6'h00;
	localparam logic [5:0] ADDR_T1_CNT_H   = 6'h01;
	localparam logic [5:0] ADDR_T1_CMPA_L  = 6'h02;
	localparam logic [5:0] ADDR_T1_CMPA_H  = 6'h03;
	localparam logic [5:0] ADDR_T1_CMPB_L  = 6'h04;
	localparam logic [5:0] ADDR_T1_CMPB_H  = 6'h05;
	localparam logic [5:0] ADDR_T1_CMPC_L  = 6'h06;
	localparam logic [5:0] ADDR_T1_CMPC_H  = 6'h07;
	localparam logic [5:0] ADDR_T1_CAP_L   = 6'h08;
	localparam logic [5:0] ADDR_T1_CAP_H   = 6'h09;
	localparam logic [5:0] ADDR_T1_FORCE   = 6'h0a;
	localparam logic [5:0] ADDR_T1_MODE    = 6'h0b;
	localparam logic [5:0] ADDR_T3_BASE    = 6'h10;
	localparam logic [5:0] ADDR_TMASK      = 6'h20;
	localparam logic [5:0] ADDR_ETMASK     = 6'h21;
	localparam logic [5:0] ADDR_TFLAGS     = 6'h22;
	localparam logic [5:0] ADDR_ETFLAGS    = 6'h23;
	localparam logic [5:0] ADDR_UNIT_MASK  = 6'h0f;
	localparam int         FORCE_A_BIT     = 7;
	localparam int         FORCE_B_BIT     = 6;
	localparam int         FORCE_C_BIT     = 5;
	localparam int         EN_CAP_BIT      = 5;
	localparam int         EN_CMPA_BIT     = 4;
	localparam int         EN_CMPB_BIT     = 3;
	localparam int         EN_OVF_BIT      = 2;
	localparam int         EN_T3_CMPC_BIT  = 1;
	localparam int         EN_T1_CMPC_BIT  = 0;
	localparam logic [7:0] TMASK_T1_BITS   = 8'h3c;
	localparam logic [7:0] ETMASK_BITS     = 8'h3f;
	localparam logic [3:0] MODE_NORMAL     = 4'h0;
	localparam logic [3:0] MODE_CTC_CMPA   = 4'h4;
	localparam logic [3:0] MODE_CTC_CAP    = 4'hc;
	localparam logic [3:0] MODE_FPWM_CAP   = 4'he;
	localparam logic [3:0] MODE_PFC_CAP    = 4'h8;
	localparam logic [3:0] MODE_PC_CAP     = 4'ha;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [15:0] COUNT_MAX      = 16'hffff;
	localparam logic [7:0]  BYTE_RESET     = 8'h00;

	// per-timer state
	typedef struct packed {
		logic [15:0]      counter_value;
		logic [2:0][15:0] compare_value;
		logic [15:0]      capture_value;
		logic [3:0]       waveform_mode_select;
		logic             match_block;
		logic [2:0]       cmp_flag;
		logic             cap_flag;
		logic             ovf_flag;
		logic [2:0]       compare_output_pin;
	} unit_t;

	typedef struct packed {
		unit_t [1:0] unit;
		logic [7:0]  temp_high;
		logic [7:0]  timer_interrupt_mask;
		logic [7:0]  extended_timer_interrupt_mask;
		logic [7:0]  rd_data;
		logic [1:0]  irq_req;
	} state_t;

	// per-timer pin-side inputs
	typedef struct packed {
		logic       tick;
		logic       capture_event;
		logic [2:0][1:0] compare_output_action;
	} unit_in_t;
endpackage

//--- hdl/timer16_compare_capture_regs.sv
// dual 16-bit timer register logic: counters, compares, captures, masks, flags
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module timer16_compare_capture_regs (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic [5:0]         addr,
	input  wire logic [7:0]         wr_data,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output logic [7:0]              rd_data,
	input  wire tmr16_pkg::unit_in_t t1_in,
	input  wire tmr16_pkg::unit_in_t t3_in,
	input  wire logic               t1_cap_from_comparator,
	input  wire logic               comparator_event,
	input  wire logic               legacy_mode,
	input  wire logic               global_irq_en,
	input  wire logic [7:0]         irq_ack,
	output logic [7:0]              irq_pending,
	output logic [2:0]              t1_compare_output_pin,
	output logic [2:0]              t3_compare_output_pin
);
	tmr16_pkg::state_t st;
	tmr16_pkg::state_t next_st;

	// ack/pending order: t1 cap,cmpa,cmpb,ovf,cmpc ; t3 cap,cmpa.. packed below
	// bit 0 t1 cap, 1 t1 a, 2 t1 b, 3 t1 ovf, 4 t1 c, 5 t3 cap, 6 t3 a, 7 t3 b (pending bit 7 also ors t3 ovf and t3 c)
	// t3 ovf and t3 c have no ack line of their own: flag writes clear them
	function automatic logic non_pwm(input logic [3:0] m);
		non_pwm = (m == tmr16_pkg::MODE_NORMAL) || (m == tmr16_pkg::MODE_CTC_CMPA)
			|| (m == tmr16_pkg::MODE_CTC_CAP);
	endfunction

	function automatic logic cap_is_top(input logic [3:0] m);
		cap_is_top = (m == tmr16_pkg::MODE_CTC_CAP) || (m == tmr16_pkg::MODE_FPWM_CAP)
			|| (m == tmr16_pkg::MODE_PFC_CAP) || (m == tmr16_pkg::MODE_PC_CAP);
	endfunction

	function automatic logic [1:0] pwm_width(input logic [3:0] m);
		pwm_width = m[1:0];
	endfunction

	function automatic logic [15:0] top_of(input tmr16_pkg::unit_t u);
		logic [3:0] m;
		m = u.waveform_mode_select;
		if (m == tmr16_pkg::MODE_NORMAL)
			top_of = tmr16_pkg::COUNT_MAX;
		else if (m == tmr16_pkg::MODE_CTC_CMPA || m == 4'h9 || m == 4'hb || m == 4'hf)
			top_of = u.compare_value[0];
		else if (cap_is_top(m))
			top_of = u.capture_value;
		else
			top_of = {6'h00, {pwm_width(m) == 2'h3, pwm_width(m) != 2'h1}, 8'hff};
	endfunction

	logic [1:0][4:0] ack;
	logic            unit_sel;
	logic [3:0]      reg_off;
	logic            unit_hit;

	assign ack[0]   = irq_ack[4:0];
	assign ack[1]   = {2'b00, irq_ack[7:5]};
	assign unit_sel = addr[4];
	assign reg_off  = addr[3:0];
	assign unit_hit = (addr[5] == 1'b0);

	always_comb begin
		tmr16_pkg::unit_t u;
		tmr16_pkg::unit_in_t ui;
		logic [15:0] nxt_cnt;
		logic        wr_here;
		logic        rd_here;
		logic        cap_ev;
		logic [2:0]  match;
		logic [2:0]  forced;
		logic        cnt_wr;
		u       = '0;
		ui      = '0;
		nxt_cnt = '0;
		wr_here = 1'b0;
		rd_here = 1'b0;
		cap_ev  = 1'b0;
		match   = '0;
		forced  = '0;
		cnt_wr  = 1'b0;
		next_st = st;
		next_st.rd_data = 8'h00;
		for (int i = 0; i < 2; i++) begin
			u       = st.unit[i];
			ui      = (i == 0) ? t1_in : t3_in;
			wr_here = wr_stb && unit_hit && (unit_sel == i[0]);
			rd_here = rd_stb && unit_hit && (unit_sel == i[0]);
			cnt_wr  = wr_here && reg_off == tmr16_pkg::ADDR_T1_CNT_L[3:0];
			for (int c = 0; c < 3; c++)
				match[c] = ui.tick && !st.unit[i].match_block
					&& (st.unit[i].counter_value == st.unit[i].compare_value[c]);
			for (int c = 0; c < 3; c++)
				forced[c] = wr_here && reg_off == tmr16_pkg::ADDR_T1_FORCE[3:0]
					&& wr_data[tmr16_pkg::FORCE_A_BIT - c] && non_pwm(u.waveform_mode_select);
			// counting; clear-on-top compares the counter with top directly, ignoring match_block and forced compares
			if (ui.tick) begin
				if (u.counter_value == top_of(u) && u.waveform_mode_select != 4'h0)
					nxt_cnt = tmr16_pkg::COUNT_RESET;
				else
					nxt_cnt = u.counter_value + 16'h0001;
				u.counter_value = nxt_cnt;
				if (nxt_cnt == tmr16_pkg::COUNT_RESET)
					u.ovf_flag = 1'b1;
				u.match_block = 1'b0;
			end
			// real match sets flag; forced never does
			for (int c = 0; c < 3; c++) begin
				if (match[c] || forced[c]) begin
					case (ui.compare_output_action[c])
						2'h1: u.compare_output_pin[c] = ~u.compare_output_pin[c];
						2'h2: u.compare_output_pin[c] = 1'b0;
						2'h3: u.compare_output_pin[c] = 1'b1;
						default: u.compare_output_pin[c] = u.compare_output_pin[c];
					endcase
				end
			end
			// capture source select; disabled when capture is top
			cap_ev = (i == 0 && t1_cap_from_comparator) ? comparator_event : ui.capture_event;
			if (cap_ev && !cap_is_top(u.waveform_mode_select))
				u.capture_value = st.unit[i].counter_value;
			// flag clear by write-one or ack, set wins
			if (wr_stb && addr == ((i == 0) ? tmr16_pkg::ADDR_TFLAGS : tmr16_pkg::ADDR_ETFLAGS)) begin
				if (wr_data[tmr16_pkg::EN_CAP_BIT])  u.cap_flag    = 1'b0;
				if (wr_data[tmr16_pkg::EN_CMPA_BIT]) u.cmp_flag[0] = 1'b0;
				if (wr_data[tmr16_pkg::EN_CMPB_BIT]) u.cmp_flag[1] = 1'b0;
				if (wr_data[tmr16_pkg::EN_OVF_BIT])  u.ovf_flag    = 1'b0;
				if (i == 1 && wr_data[tmr16_pkg::EN_T3_CMPC_BIT])
					u.cmp_flag[2] = 1'b0;
			end
			// timer 1 channel c flag lives in the extended flag register
			if (i == 0 && wr_stb && addr == tmr16_pkg::ADDR_ETFLAGS
					&& wr_data[tmr16_pkg::EN_T1_CMPC_BIT])
				u.cmp_flag[2] = 1'b0;
			if (ack[i][0]) u.cap_flag = 1'b0;
			if (ack[i][1]) u.cmp_flag[0] = 1'b0;
			if (ack[i][2]) u.cmp_flag[1] = 1'b0;
			if (ack[i][3]) u.ovf_flag = 1'b0;
			if (ack[i][4]) u.cmp_flag[2] = 1'b0;
			u.cmp_flag = u.cmp_flag | match;
			// capture pin is disconnected while capture value is top
			if ((cap_ev && !cap_is_top(u.waveform_mode_select))
					|| (ui.tick && cap_is_top(u.waveform_mode_select)
					&& st.unit[i].counter_value == st.unit[i].capture_value))
				u.cap_flag = 1'b1;
			if (ui.tick && nxt_cnt == tmr16_pkg::COUNT_RESET)
				u.ovf_flag = 1'b1;
			// high byte to temp, low byte commits
			if (wr_here) begin
				case (reg_off)
					4'h1, 4'h3, 4'h5, 4'h7, 4'h9: next_st.temp_high = wr_data;
					4'h0: begin
						u.counter_value = {st.temp_high, wr_data};
						u.match_block = cnt_wr;
					end
					4'h2: u.compare_value[0] = {st.temp_high, wr_data};
					4'h4: u.compare_value[1] = {st.temp_high, wr_data};
					4'h6: u.compare_value[2] = {st.temp_high, wr_data};
					4'h8: u.capture_value = {st.temp_high, wr_data};
					4'hb: u.waveform_mode_select = wr_data[3:0];
					default: u.match_block = u.match_block;
				endcase
			end
			if (rd_here) begin
				case (reg_off)
					4'h0: begin
						next_st.rd_data   = st.unit[i].counter_value[7:0];
						next_st.temp_high = st.unit[i].counter_value[15:8];
					end
					4'h2: begin
						next_st.rd_data   = st.unit[i].compare_value[0][7:0];
						next_st.temp_high = st.unit[i].compare_value[0][15:8];
					end
					4'h4: begin
						next_st.rd_data   = st.unit[i].compare_value[1][7:0];
						next_st.temp_high = st.unit[i].compare_value[1][15:8];
					end
					4'h6: begin
						next_st.rd_data   = st.unit[i].compare_value[2][7:0];
						next_st.temp_high = st.unit[i].compare_value[2][15:8];
					end
					4'h8: begin
						next_st.rd_data   = st.unit[i].capture_value[7:0];
						next_st.temp_high = st.unit[i].capture_value[15:8];
					end
					4'h1, 4'h3, 4'h5, 4'h7, 4'h9: next_st.rd_data = st.temp_high;
					4'ha: next_st.rd_data = 8'h00;
					4'hb: next_st.rd_data = {4'h0, st.unit[i].waveform_mode_select};
					default: next_st.rd_data = 8'h00;
				endcase
			end
			next_st.unit[i] = u;
		end
		if (wr_stb && addr == tmr16_pkg::ADDR_TMASK)
			next_st.timer_interrupt_mask = wr_data & tmr16_pkg::TMASK_T1_BITS;
		// extended mask absent in legacy mode
		if (wr_stb && addr == tmr16_pkg::ADDR_ETMASK && !legacy_mode)
			next_st.extended_timer_interrupt_mask = wr_data & tmr16_pkg::ETMASK_BITS;
		if (rd_stb) begin
			case (addr)
				tmr16_pkg::ADDR_TMASK:   next_st.rd_data = st.timer_interrupt_mask;
				tmr16_pkg::ADDR_ETMASK:
					next_st.rd_data = legacy_mode ? 8'h00 : st.extended_timer_interrupt_mask;
				tmr16_pkg::ADDR_TFLAGS:
					next_st.rd_data = {2'b00, st.unit[0].cap_flag, st.unit[0].cmp_flag[0],
						st.unit[0].cmp_flag[1], st.unit[0].ovf_flag, 2'b00};
				tmr16_pkg::ADDR_ETFLAGS:
					next_st.rd_data = {2'b00, st.unit[1].cap_flag, st.unit[1].cmp_flag[0],
						st.unit[1].cmp_flag[1], st.unit[1].ovf_flag,
						st.unit[1].cmp_flag[2], st.unit[0].cmp_flag[2]};
				default: next_st.rd_data = next_st.rd_data;
			endcase
		end
		next_st.irq_req = '0;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// pending: enable and flag and global enable, registered
	logic [7:0] next_pending;
	logic [7:0] et_m;
	assign et_m = legacy_mode ? 8'h00 : st.extended_timer_interrupt_mask;
	always_comb begin
		next_pending[0] = st.timer_interrupt_mask[tmr16_pkg::EN_CAP_BIT] && st.unit[0].cap_flag;
		next_pending[1] = st.timer_interrupt_mask[tmr16_pkg::EN_CMPA_BIT] && st.unit[0].cmp_flag[0];
		next_pending[2] = st.timer_interrupt_mask[tmr16_pkg::EN_CMPB_BIT] && st.unit[0].cmp_flag[1];
		next_pending[3] = st.timer_interrupt_mask[tmr16_pkg::EN_OVF_BIT] && st.unit[0].ovf_flag;
		next_pending[4] = et_m[tmr16_pkg::EN_T1_CMPC_BIT] && st.unit[0].cmp_flag[2];
		next_pending[5] = et_m[tmr16_pkg::EN_CAP_BIT] && st.unit[1].cap_flag;
		next_pending[6] = et_m[tmr16_pkg::EN_CMPA_BIT] && st.unit[1].cmp_flag[0];
		next_pending[7] = (et_m[tmr16_pkg::EN_CMPB_BIT] && st.unit[1].cmp_flag[1])
			|| (et_m[tmr16_pkg::EN_OVF_BIT] && st.unit[1].ovf_flag)
			|| (et_m[tmr16_pkg::EN_T3_CMPC_BIT] && st.unit[1].cmp_flag[2]);
		if (!global_irq_en)
			next_pending = 8'h00;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_pending           <= 8'h00;
			rd_data               <= 8'h00;
			t1_compare_output_pin <= 3'b000;
			t3_compare_output_pin <= 3'b000;
		end else begin
			irq_pending           <= next_pending;
			rd_data               <= next_st.rd_data;
			t1_compare_output_pin <= next_st.unit[0].compare_output_pin;
			t3_compare_output_pin <= next_st.unit[1].compare_output_pin;
		end
	end
endmodule // timer16_compare_capture_regs

//--- verif/timer16_compare_capture_regs_props.sv
// checker: port-level properties of the dual timer register block
`timescale 1ns/1ps
module timer16_compare_capture_regs_props (
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic [5:0]          addr,
	input wire logic [7:0]          wr_data,
	input wire logic                wr_stb,
	input wire logic                rd_stb,
	input wire logic [7:0]          rd_data,
	input wire tmr16_pkg::unit_in_t t1_in,
	input wire tmr16_pkg::unit_in_t t3_in,
	input wire logic                legacy_mode,
	input wire logic                global_irq_en,
	input wire logic [7:0]          irq_pending,
	input wire logic [2:0]          t1_compare_output_pin,
	input wire logic [2:0]          t3_compare_output_pin
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence pair_wr;
		wr_stb && addr == 6'h03 ##1 wr_stb && addr == 6'h02;
	endsequence
	sequence pair_rd;
		rd_stb && addr == 6'h02 ##1 rd_stb && addr == 6'h03;
	endsequence
	rd_idle_zero_a:
		assert property (!rd_stb |=> rd_data == 8'h00) else $error("read data outside a read");
	force_read_zero_a:
		assert property (rd_stb && addr[3:0] == 4'ha && !addr[5] |=> rd_data == 8'h00)
		else $error("force register read not zero");
	legacy_mask_gone_a:
		assert property (rd_stb && legacy_mode && addr == 6'h21 |=> rd_data == 8'h00)
		else $error("extended mask visible in legacy mode");
	legacy_pend_gate_a:
		assert property (legacy_mode ##1 legacy_mode |-> irq_pending[7:4] == 4'h0)
		else $error("extended request pending in legacy mode");
	global_gate_a:
		assert property (!global_irq_en [*2] |-> irq_pending == 8'h00)
		else $error("request pending while globally disabled");
	pin_hold_a:
		assert property (!wr_stb && !t1_in.tick && !t3_in.tick |=>
			$stable({t1_compare_output_pin, t3_compare_output_pin}))
		else $error("compare pin moved without strobe or tick");
	cmp_low_a:
		assert property (pair_wr ##1 rd_stb && addr == 6'h02 |=> rd_data == $past(wr_data, 2))
		else $error("compare low byte wrong");
	cmp_high_a:
		assert property (pair_wr ##1 pair_rd |=> rd_data == $past(wr_data, 4))
		else $error("compare high byte wrong");
endmodule // timer16_compare_capture_regs_props

bind timer16_compare_capture_regs timer16_compare_capture_regs_props chk (
	.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .rd_data(rd_data), .t1_in(t1_in), .t3_in(t3_in),
	.legacy_mode(legacy_mode), .global_irq_en(global_irq_en), .irq_pending(irq_pending),
	.t1_compare_output_pin(t1_compare_output_pin), .t3_compare_output_pin(t3_compare_output_pin)
);

//--- verif/timer16_compare_capture_regs_tb_top.sv
// testbench: bus, force, capture and compare checks of the dual timer block
`timescale 1ns/1ps
module timer16_compare_capture_regs_tb_top;
	logic                clk_sys = 1'b0;
	logic                rst = 1'b1;
	logic [5:0]          addr = 6'h00;
	logic [7:0]          wr_data = 8'h00;
	logic                wr_stb = 1'b0;
	logic                rd_stb = 1'b0;
	logic [7:0]          rd_data;
	tmr16_pkg::unit_in_t t1_in = '0;
	tmr16_pkg::unit_in_t t3_in = '0;
	logic                cap_sel = 1'b0;
	logic                cmp_evt = 1'b0;
	logic                legacy_mode = 1'b0;
	logic                global_irq_en = 1'b0;
	logic [7:0]          irq_ack = 8'h00;
	logic [7:0]          irq_pending;
	logic [2:0]          t1_pin;
	logic [2:0]          t3_pin;
	int                  n_errors = 0;
	int                  checked = 0;
	logic [31:0]         seed = 32'hc1b4189b;
	logic [15:0]         cmp_model [2][3];

	timer16_compare_capture_regs uut (
		.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rd_data(rd_data), .t1_in(t1_in), .t3_in(t3_in),
		.t1_cap_from_comparator(cap_sel), .comparator_event(cmp_evt),
		.legacy_mode(legacy_mode), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
		.irq_pending(irq_pending), .t1_compare_output_pin(t1_pin), .t3_compare_output_pin(t3_pin)
	);

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one bus cycle; rd_data seen here belongs to the read one call back
	task automatic op(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
		wr_stb <= w;
		rd_stb <= r;
		addr <= a;
		wr_data <= d;
		@(posedge clk_sys);
	endtask

	task automatic idle(input int n);
		repeat (n) op(1'b0, 1'b0, 6'h00, 8'h00);
	endtask

	task automatic wr8(input logic [5:0] a, input logic [7:0] d);
		op(1'b1, 1'b0, a, d);
	endtask

	task automatic rd8(input logic [5:0] a, input logic [7:0] exp);
		op(1'b0, 1'b1, a, 8'h00);
		idle(1);
		chk(16'(rd_data), 16'(exp));
	endtask

	// high byte first, low byte commits
	task automatic write16(input logic [5:0] a, input logic [15:0] v);
		op(1'b1, 1'b0, a + 6'h01, v[15:8]);
		op(1'b1, 1'b0, a, v[7:0]);
	endtask

	task automatic read16(input logic [5:0] a, input logic [15:0] exp);
		logic [7:0] lo_b;
		op(1'b0, 1'b1, a, 8'h00);
		op(1'b0, 1'b1, a + 6'h01, 8'h00);
		lo_b = rd_data;
		idle(1);
		chk({rd_data, lo_b}, exp);
	endtask

	task automatic pulse_tick(input int n);
		repeat (n) begin
			t1_in.tick <= 1'b1;
			idle(1);
			t1_in.tick <= 1'b0;
			idle(1);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		close_out();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
			read16(6'(i < 3 ? 2 + 2 * i : 18), 16'h0000);
		rd8(6'h0a, 8'h00);
		rd8(6'h1a, 8'h00);
		for (int u = 0; u < 2; u++)
			for (int c = 0; c < 3; c++) begin
				cmp_model[u][c] = 16'(xorshift());
				write16(6'(16 * u + 2 + 2 * c), cmp_model[u][c]);
				read16(6'(16 * u + 2 + 2 * c), cmp_model[u][c]);
			end
		// one latch shared by both timers
		op(1'b1, 1'b0, 6'h03, 8'h11);
		op(1'b1, 1'b0, 6'h12, 8'h22);
		read16(6'h12, 16'h1122);
		read16(6'h02, cmp_model[0][0]);
		write16(6'h00, 16'h2468);
		read16(6'h00, 16'h2468);
		wr8(6'h20, 8'hff);
		rd8(6'h20, tmr16_pkg::TMASK_T1_BITS);
		// reserved mask bits written as zero
		wr8(6'h21, 8'h2a);
		legacy_mode <= 1'b1;
		wr8(6'h21, 8'h15);
		rd8(6'h21, 8'h00);
		legacy_mode <= 1'b0;
		rd8(6'h21, 8'h2a);
		wr8(6'h20, 8'h00);
		wr8(6'h21, 8'h00);
		wr8(6'h30, 8'h55);
		rd8(6'h30, 8'h00);
		// set, clear, toggle, none; CLEAR_ON_COMPARE_MODE on timer 1, normal on timer 3
		for (int u = 0; u < 2; u++) begin
			wr8(6'(16 * u + 11), {4'h0, u ? tmr16_pkg::MODE_NORMAL : tmr16_pkg::MODE_CTC_CMPA});
			for (int c = 0; c < 3; c++)
				for (int k = 0; k < 4; k++) begin
					if (u == 0)
						t1_in.compare_output_action[c] <= 2'(3 - k);
					else
						t3_in.compare_output_action[c] <= 2'(3 - k);
					wr8(6'(16 * u + 10), 8'h80 >> c);
					idle(2);
					chk(16'(u ? t3_pin[c] : t1_pin[c]), 16'(k != 1));
				end
		end
		rd8(6'h22, 8'h00);
		rd8(6'h23, 8'h00);
		read16(6'h00, 16'h2468);
		wr8(6'h0b, {4'h0, tmr16_pkg::MODE_FPWM_CAP});
		t1_in.compare_output_action[0] <= 2'h1;
		wr8(6'h0a, 8'h80);
		idle(2);
		chk(16'(t1_pin[0]), 16'h0001);
		wr8(6'h0b, 8'h00);
		t1_in.capture_event <= 1'b1;
		idle(1);
		t1_in.capture_event <= 1'b0;
		read16(6'h08, 16'h2468);
		rd8(6'h22, 8'h20);
		wr8(6'h22, 8'h20);
		rd8(6'h22, 8'h00);
		cap_sel <= 1'b1;
		write16(6'h00, 16'h0abc);
		cmp_evt <= 1'b1;
		idle(1);
		cmp_evt <= 1'b0;
		read16(6'h08, 16'h0abc);
		wr8(6'h22, 8'h20);
		write16(6'h04, 16'h8000);
		write16(6'h06, 16'h8000);
		write16(6'h02, 16'h0005);
		write16(6'h00, 16'h0005);
		pulse_tick(1);
		rd8(6'h22, 8'h00);
		write16(6'h00, 16'h0004);
		pulse_tick(3);
		rd8(6'h22, 8'h10);
		global_irq_en <= 1'b1;
		wr8(6'h20, 8'h10);
		idle(3);
		chk(16'(irq_pending), 16'h0002);
		irq_ack <= 8'h02;
		idle(1);
		irq_ack <= 8'h00;
		idle(3);
		chk(16'(irq_pending), 16'h0000);
		rd8(6'h22, 8'h00);
		// capture value as top: wrap there, flag at top, comparator event ignored
		write16(6'h08, 16'h0003);
		wr8(6'h0b, {4'h0, tmr16_pkg::MODE_CTC_CAP});
		write16(6'h00, 16'h0002);
		wr8(6'h20, 8'h20);
		pulse_tick(2);
		read16(6'h00, 16'h0000);
		chk(16'(irq_pending), 16'h0001);
		wr8(6'h22, 8'h20);
		cmp_evt <= 1'b1;
		idle(1);
		cmp_evt <= 1'b0;
		read16(6'h08, 16'h0003);
		chk(16'(irq_pending), 16'h0000);
		// timer 1 channel c flag sits in the extended flag register
		write16(6'h06, 16'h0001);
		pulse_tick(2);
		rd8(6'h23, 8'h01);
		wr8(6'h23, 8'h01);
		rd8(6'h23, 8'h00);
		close_out();
	end
endmodule // timer16_compare_capture_regs_tb_top
